// ### rtl/disk_cyl_map.svh
// Register offsets, field positions, reset values and timing counts for the cylinder and error registers
// Overview of operation
// - The target cylinder register holds the 13-bit cylinder for seek, search and data commands; its top three bits read zero.
// - The holding register is not emulated and always reads zero whatever is written.
// - The second maintenance register is decoded but always reads sixteen zero bits.
// - The secondary drive error register answers at its host bus address and its system bus offset as 16 bits.
// - Bad sector is set when bit 14 or 15 of the first header word is zero, only while header compare inhibit is clear.
// - Seek incomplete is set when a seek has not finished within 500 ms of its start.
// - Seek incomplete clears on bus initialize, controller clear, or a write of zeros to the secondary error register.
// - Invalid command is set when volume valid or medium online is low and a command other than preset, ack, clear or no-op arrives.
// - Invalid command clears on bus initialize, drive clear, controller clear, or a write of zeros to the register.
// - Device check is set while the drive fault line is asserted, and the unsafe flag is raised with it.
// - Drive plug, clock loss, bit clock loss, parity and all unused bits of the secondary error register read zero.
// - While header compare inhibit is set, sectors are found by the sector counter only and headers are not checked.
`ifndef DISK_CYL_MAP_SVH
`define DISK_CYL_MAP_SVH

// Host bus addresses and system bus offsets
`define ADDR_TARGET_CYL_HOST 18'h3FDDC
`define ADDR_HOLDING_HOST 18'h3FDDE
`define ADDR_MAINT_TWO_HOST 18'h3FDE0
`define ADDR_ERROR_TWO_HOST 18'h3FDE2
`define ADDR_TARGET_CYL_SYS 18'h00428
`define ADDR_HOLDING_SYS 18'h0042C
`define ADDR_MAINT_TWO_SYS 18'h00430
`define ADDR_ERROR_TWO_SYS 18'h00434

`define CYL_WIDTH 13
`define TARGET_CYL_RESET 13'h0000
`define READ_ZERO 16'h0000

// Secondary error register bit positions
`define BIT_BAD_SECTOR 15
`define BIT_SEEK_INCOMPLETE 14
`define BIT_INVALID_COMMAND 12
`define BIT_DEVICE_CHECK 7

// Header word bits that mark a good sector
`define HDR_GOOD_HI 15
`define HDR_GOOD_LO 14

// Function codes
`define FN_NOP 5'h00
`define FN_SEEK 5'h02
`define FN_DRIVE_CLEAR 5'h04
`define FN_PRESET 5'h08
`define FN_PACK_ACK 5'h09
`define FN_SEARCH 5'h0C
`define FN_DATA_FIRST 5'h14

// Seek timeout
`define SEEK_TIMEOUT_MS 500
`define CLOCK_KHZ 25000
`define SEEK_TIMEOUT_CYCLES (`SEEK_TIMEOUT_MS * `CLOCK_KHZ)

`endif

// ### rtl/disk_cyl_pkg.sv
// Types shared by the cylinder and error register block
package disk_cyl_pkg;

   typedef enum logic [2:0] {
      SEL_NONE = 3'h0,
      SEL_TARGET_CYL = 3'h1,
      SEL_HOLDING = 3'h2,
      SEL_MAINT_TWO = 3'h3,
      SEL_ERROR_TWO = 3'h4
   } reg_sel_t;

   typedef enum logic [1:0] {
      SEEK_IDLE = 2'b00,
      SEEK_RUN = 2'b01,
      SEEK_LATE = 2'b11
   } seek_state_t;

endpackage

// ### rtl/seek_watchdog.sv
// Seek watchdog: flags a seek that has not finished within the timeout
`timescale 1ns/1ps
`include "disk_cyl_map.svh"

module seek_watchdog
   import disk_cyl_pkg::*;
#(
   parameter int unsigned TIMEOUT_CYCLES = `SEEK_TIMEOUT_CYCLES,
   parameter int unsigned COUNT_WIDTH = 24
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Seek events
   input wire logic abort,
   input wire logic seek_start,
   input wire logic seek_done,
   // Result
   output logic timeout_q
);

   initial begin
      if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (64'd1 << COUNT_WIDTH)) begin
         $error("seek_watchdog: TIMEOUT_CYCLES does not fit COUNT_WIDTH");
      end
   end

   localparam logic [COUNT_WIDTH-1:0] LAST_COUNT = COUNT_WIDTH'(TIMEOUT_CYCLES - 1);

   seek_state_t state_q;
   logic [COUNT_WIDTH-1:0] count_q;

   always_ff @(posedge clock) begin
      if (!rst_n || abort) begin
         state_q <= SEEK_IDLE;
      end else begin
         case (state_q)
            SEEK_IDLE: begin
               if (seek_start) begin
                  state_q <= SEEK_RUN;
               end
            end
            SEEK_RUN: begin
               if (seek_done) begin
                  state_q <= SEEK_IDLE;
               end else if (count_q == LAST_COUNT) begin
                  state_q <= SEEK_LATE;
               end
            end
            SEEK_LATE: state_q <= SEEK_IDLE;
            default: state_q <= SEEK_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n || state_q != SEEK_RUN) begin
         count_q <= '0;
      end else begin
         count_q <= count_q + 1'b1;
      end
   end

   // One pulse when the limit passes with the seek still open
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         timeout_q <= 1'b0;
      end else begin
         timeout_q <= (state_q == SEEK_RUN) && !seek_done && (count_q == LAST_COUNT);
      end
   end

endmodule

// ### rtl/disk_cylinder_error_regs.sv
// Target cylinder, stub registers and secondary drive error register
`timescale 1ns/1ps
`include "disk_cyl_map.svh"

module disk_cylinder_error_regs
   import disk_cyl_pkg::*;
#(
   parameter int unsigned SEEK_TIMEOUT_CYCLES = `SEEK_TIMEOUT_CYCLES,
   parameter int unsigned SEEK_COUNT_WIDTH = 24
) (
   // Clock and host bus initialize
   input wire logic clock,
   input wire logic rst_n,
   // Register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [17:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   output logic [15:0] reg_rdata,
   output logic reg_ack,
   // Command from the control register logic
   input wire logic cmd_go,
   input wire logic [4:0] cmd_function,
   input wire logic controller_clear,
   // Drive status and offset control bits
   input wire logic volume_valid,
   input wire logic medium_online,
   input wire logic header_compare_inhibit,
   input wire logic [12:0] last_cylinder,
   // Header word from the read path
   input wire logic hdr_valid,
   input wire logic [15:0] hdr_word,
   // Drive pins
   input wire logic drive_fault,
   input wire logic seek_finished,
   // Outputs to the drive and primary error register
   output logic [12:0] cylinder_field,
   output logic address_error_set,
   output logic unsafe_flag,
   output logic header_check_en
);

   initial begin
      if (SEEK_COUNT_WIDTH < 2 || SEEK_COUNT_WIDTH > 32) begin
         $error("disk_cylinder_error_regs: SEEK_COUNT_WIDTH out of range");
      end
   end

   function automatic reg_sel_t decode(input logic [17:0] addr);
      reg_sel_t sel;
      sel = SEL_NONE;
      case (addr)
         `ADDR_TARGET_CYL_HOST, `ADDR_TARGET_CYL_SYS: sel = SEL_TARGET_CYL;
         `ADDR_HOLDING_HOST, `ADDR_HOLDING_SYS: sel = SEL_HOLDING;
         `ADDR_MAINT_TWO_HOST, `ADDR_MAINT_TWO_SYS: sel = SEL_MAINT_TWO;
         `ADDR_ERROR_TWO_HOST, `ADDR_ERROR_TWO_SYS: sel = SEL_ERROR_TWO;
         default: sel = SEL_NONE;
      endcase
      return sel;
   endfunction

   function automatic logic is_positioning(input logic [4:0] fn);
      return (fn == `FN_SEEK) || (fn == `FN_SEARCH) || (fn >= `FN_DATA_FIRST);
   endfunction

   reg_sel_t sel;
   logic wr_err2;
   logic drive_clear_cmd;
   logic positioning_go;
   logic allowed_offline;
   logic seek_timeout;
   assign sel = decode(reg_addr);
   assign wr_err2 = reg_wr && (sel == SEL_ERROR_TWO);
   assign drive_clear_cmd = cmd_go && (cmd_function == `FN_DRIVE_CLEAR);
   assign positioning_go = cmd_go && is_positioning(cmd_function);
   assign allowed_offline = (cmd_function == `FN_PRESET) || (cmd_function == `FN_PACK_ACK) ||
                            (cmd_function == `FN_DRIVE_CLEAR) || (cmd_function == `FN_NOP);

   // Pin synchronisers: a change counts once the second and third stages agree
   logic [2:0] fault_sync_q;
   logic [2:0] done_sync_q;
   logic fault_q;
   logic done_level_q;
   logic done_level_prev_q;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         fault_sync_q <= 3'h0;
         done_sync_q <= 3'h0;
      end else begin
         fault_sync_q <= {fault_sync_q[1:0], drive_fault};
         done_sync_q <= {done_sync_q[1:0], seek_finished};
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         fault_q <= 1'b0;
         done_level_q <= 1'b0;
         done_level_prev_q <= 1'b0;
      end else begin
         if (fault_sync_q[1] == fault_sync_q[2]) begin
            fault_q <= fault_sync_q[2];
         end
         if (done_sync_q[1] == done_sync_q[2]) begin
            done_level_q <= done_sync_q[2];
         end
         done_level_prev_q <= done_level_q;
      end
   end

   // Target cylinder
   logic [`CYL_WIDTH-1:0] target_cyl_q;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         target_cyl_q <= `TARGET_CYL_RESET;
      end else if (reg_wr && sel == SEL_TARGET_CYL) begin
         target_cyl_q <= reg_wdata[`CYL_WIDTH-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         cylinder_field <= `TARGET_CYL_RESET;
         address_error_set <= 1'b0;
      end else begin
         cylinder_field <= target_cyl_q;
         address_error_set <= positioning_go && (target_cyl_q > last_cylinder);
      end
   end

   // Seek watchdog
   seek_watchdog #(
      .TIMEOUT_CYCLES(SEEK_TIMEOUT_CYCLES),
      .COUNT_WIDTH(SEEK_COUNT_WIDTH)
   ) u_seek_watchdog (
      .clock(clock),
      .rst_n(rst_n),
      .abort(controller_clear),
      .seek_start(cmd_go && cmd_function == `FN_SEEK),
      .seek_done(done_level_q && !done_level_prev_q),
      .timeout_q(seek_timeout)
   );

   // Error flags: a set in the clearing cycle wins
   logic bad_sector_flag_q;
   logic seek_incomplete_flag_q;
   logic invalid_command_flag_q;
   logic device_check_flag_q;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         bad_sector_flag_q <= 1'b0;
      end else if (hdr_valid && !header_compare_inhibit &&
                   (!hdr_word[`HDR_GOOD_HI] || !hdr_word[`HDR_GOOD_LO])) begin
         bad_sector_flag_q <= 1'b1;
      end else if (controller_clear || drive_clear_cmd || (wr_err2 && !reg_wdata[`BIT_BAD_SECTOR])) begin
         bad_sector_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         seek_incomplete_flag_q <= 1'b0;
      end else if (seek_timeout) begin
         seek_incomplete_flag_q <= 1'b1;
      end else if (controller_clear || (wr_err2 && !reg_wdata[`BIT_SEEK_INCOMPLETE])) begin
         seek_incomplete_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         invalid_command_flag_q <= 1'b0;
      end else if (cmd_go && (!volume_valid || !medium_online) && !allowed_offline) begin
         invalid_command_flag_q <= 1'b1;
      end else if (controller_clear || drive_clear_cmd ||
                   (wr_err2 && !reg_wdata[`BIT_INVALID_COMMAND])) begin
         invalid_command_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         device_check_flag_q <= 1'b0;
         unsafe_flag <= 1'b0;
      end else begin
         unsafe_flag <= fault_q;
         if (fault_q) begin
            device_check_flag_q <= 1'b1;
         end else if (controller_clear || drive_clear_cmd ||
                      (wr_err2 && !reg_wdata[`BIT_DEVICE_CHECK])) begin
            device_check_flag_q <= 1'b0;
         end
      end
   end

   // Header checking is off while compare inhibit is set
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         header_check_en <= 1'b1;
      end else begin
         header_check_en <= !header_compare_inhibit;
      end
   end

   // Read data
   logic [15:0] err2_value;
   always_comb begin
      err2_value = `READ_ZERO;
      err2_value[`BIT_BAD_SECTOR] = bad_sector_flag_q;
      err2_value[`BIT_SEEK_INCOMPLETE] = seek_incomplete_flag_q;
      err2_value[`BIT_INVALID_COMMAND] = invalid_command_flag_q;
      err2_value[`BIT_DEVICE_CHECK] = device_check_flag_q;
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         reg_rdata <= `READ_ZERO;
         reg_ack <= 1'b0;
      end else begin
         reg_ack <= (reg_rd || reg_wr) && (sel != SEL_NONE);
         if (reg_rd) begin
            case (sel)
               SEL_TARGET_CYL: reg_rdata <= {3'h0, target_cyl_q};
               SEL_HOLDING: reg_rdata <= `READ_ZERO;
               SEL_MAINT_TWO: reg_rdata <= `READ_ZERO;
               SEL_ERROR_TWO: reg_rdata <= err2_value;
               default: reg_rdata <= `READ_ZERO;
            endcase
         end else begin
            reg_rdata <= `READ_ZERO;
         end
      end
   end

endmodule

// ### verif/disk_cyl_checker.sv
// Concurrent checks on the cylinder and error register block ports
`timescale 1ns/1ps
`include "disk_cyl_map.svh"

module disk_cyl_checker (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [17:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic reg_ack,
   // Command, status and drive side
   input wire logic cmd_go,
   input wire logic [4:0] cmd_function,
   input wire logic header_compare_inhibit,
   input wire logic [12:0] last_cylinder,
   input wire logic drive_fault,
   input wire logic [12:0] cylinder_field,
   input wire logic address_error_set,
   input wire logic unsafe_flag,
   input wire logic header_check_en
);
   wire err_a = reg_addr == `ADDR_ERROR_TWO_HOST || reg_addr == `ADDR_ERROR_TWO_SYS;
   wire hold_a = reg_addr == `ADDR_HOLDING_HOST || reg_addr == `ADDR_HOLDING_SYS;
   wire mnt_a = reg_addr == `ADDR_MAINT_TWO_HOST || reg_addr == `ADDR_MAINT_TWO_SYS;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   chk_cyl_top: assert property (reg_rd && reg_addr == `ADDR_TARGET_CYL_HOST |=> reg_rdata[15:13] == 3'h0)
      else $error("cylinder top bits set");
   chk_cyl_follow: assert property (reg_wr && reg_addr == `ADDR_TARGET_CYL_SYS |=> ##1
      {3'h0, cylinder_field} == ($past(reg_wdata, 2) & 16'h1FFF)) else $error("cylinder not passed on");
   chk_addr_error: assert property (cmd_go && cmd_function == `FN_SEEK && cylinder_field > last_cylinder
      |=> address_error_set) else $error("address error missing");
   chk_no_addr_err: assert property (!cmd_go |=> !address_error_set)
      else $error("address error without go");
   chk_holding_zero: assert property (reg_rd && hold_a |=> reg_rdata == 16'h0000)
      else $error("holding reads nonzero");
   chk_maint_zero: assert property (reg_rd && mnt_a |=> reg_rdata == 16'h0000)
      else $error("maintenance reads nonzero");
   chk_error_ack: assert property ((reg_rd || reg_wr) && err_a |=> reg_ack)
      else $error("error register not acked");
   chk_unused_zero: assert property (reg_rd && err_a |=> (reg_rdata & 16'h2F7F) == 16'h0000)
      else $error("unused error bits set");
   chk_fault_unsafe: assert property (drive_fault [*8] |=> unsafe_flag)
      else $error("unsafe not raised");
   chk_hci_off: assert property (header_compare_inhibit [*2] |=> !header_check_en)
      else $error("header check still on");
   cover property (address_error_set);
   cover property ($rose(unsafe_flag));
   cover property (reg_ack && reg_rdata[12]);
endmodule

bind disk_cylinder_error_regs disk_cyl_checker u_chk (.clock, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
   .reg_rdata, .reg_ack, .cmd_go, .cmd_function, .header_compare_inhibit, .last_cylinder, .drive_fault,
   .cylinder_field, .address_error_set, .unsafe_flag, .header_check_en);

// ### verif/drive_model.sv
// Disk drive model: ends seeks after a set delay and raises its fault line on request
`timescale 1ns/1ps
`include "disk_cyl_map.svh"

module drive_model (
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Commands seen by the drive
   input wire logic cmd_go,
   input wire logic [4:0] cmd_function,
   input wire logic [7:0] seek_delay,
   input wire logic fault_on,
   // Drive pins
   output logic drive_fault,
   output logic seek_finished
);
   int cnt;
   assign drive_fault = fault_on;
   // Finish line drops at each seek start and rises once the delay has run out
   always_ff @(posedge clock) begin
      if (!rst_n || (cmd_go && cmd_function == `FN_SEEK)) begin
         cnt <= rst_n ? int'(seek_delay) : 0;
         seek_finished <= 1'b0;
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
         seek_finished <= (cnt == 1);
      end
   end
endmodule

// ### verif/tb_disk_cylinder_error_regs.sv
// Self-checking bench for the cylinder and error register block
`timescale 1ns/1ps
`include "disk_cyl_map.svh"

module tb_disk_cylinder_error_regs;
   import disk_cyl_pkg::*;
   logic clock = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, cmd_go = 0, controller_clear = 0, hdr_valid = 0;
   logic volume_valid = 1, medium_online = 1, header_compare_inhibit = 0, fault_on = 0;
   logic [17:0] reg_addr = 0;
   logic [15:0] reg_wdata = 0, hdr_word = 0, reg_rdata;
   logic [12:0] last_cylinder = 0, cylinder_field;
   logic [4:0] cmd_function = 0;
   logic [7:0] seek_delay = 0;
   logic reg_ack, address_error_set, unsafe_flag, header_check_en, drive_fault, seek_finished;
   int num_errors = 0, n_compared = 0, ee = 0, w;
   logic [15:0] hw [3] = '{16'hC000, 16'h7FFF, 16'h0000};
   logic [4:0] fns [6] = '{`FN_SEARCH, `FN_NOP, `FN_PRESET, `FN_PACK_ACK, `FN_DRIVE_CLEAR, `FN_DATA_FIRST};

   always #20 clock = ~clock;

   disk_cylinder_error_regs #(.SEEK_TIMEOUT_CYCLES(20)) DUT (.clock, .rst_n, .reg_wr, .reg_rd, .reg_addr,
      .reg_wdata, .reg_rdata, .reg_ack, .cmd_go, .cmd_function, .controller_clear, .volume_valid, .medium_online,
      .header_compare_inhibit, .last_cylinder, .hdr_valid, .hdr_word, .drive_fault, .seek_finished,
      .cylinder_field, .address_error_set, .unsafe_flag, .header_check_en);
   drive_model drv (.clock, .rst_n, .cmd_go, .cmd_function, .seek_delay, .fault_on, .drive_fault, .seek_finished);

   task automatic tick(int n = 1);
      repeat (n) @(posedge clock);
      #1;
   endtask

   task automatic cmp(logic [15:0] got, logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(logic [17:0] a, logic [15:0] d);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1;
      tick();
      reg_wr = 0;
   endtask

   task automatic rd(logic [17:0] a, logic [15:0] e, logic k = 1);
      reg_addr = a;
      reg_rd = 1;
      tick();
      reg_rd = 0;
      cmp(16'(reg_ack), 16'(k));
      cmp(reg_rdata, e);
   endtask

   task automatic go(logic [4:0] f);
      cmd_function = f;
      cmd_go = 1;
      tick();
      cmd_go = 0;
   endtask

   task automatic close_out();
      $display("compared %0d, errors %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      void'($urandom(79249));
      tick(2);
      rst_n = 1;
      tick(2);
      w = $urandom_range(8191, 1);
      wr(`ADDR_TARGET_CYL_SYS, 16'hE000 | 16'(w));
      rd(`ADDR_TARGET_CYL_HOST, 16'(w));
      cmp(16'(cylinder_field), 16'(w));
      wr(`ADDR_HOLDING_HOST, 16'hFFFF);
      rd(`ADDR_HOLDING_SYS, 16'h0000);
      wr(`ADDR_MAINT_TWO_SYS, 16'hFFFF);
      rd(`ADDR_MAINT_TWO_HOST, 16'h0000);
      rd(18'h3FDE4, 16'h0000, 0);
      rd(`ADDR_ERROR_TWO_SYS, 16'h0000);
      // Prompt seek one past the last cylinder, then a stalled seek at the boundary
      last_cylinder = 13'(w - 1);
      seek_delay = 8'h05;
      go(`FN_SEEK);
      cmp(16'(address_error_set), 16'h0001);
      tick(30);
      rd(`ADDR_ERROR_TWO_HOST, 16'h0000);
      last_cylinder = 13'(w);
      seek_delay = 8'hC8;
      go(`FN_SEEK);
      cmp(16'(address_error_set), 16'h0000);
      tick(30);
      rd(`ADDR_ERROR_TWO_HOST, 16'h4000);
      controller_clear = 1;
      tick();
      controller_clear = 0;
      rd(`ADDR_ERROR_TWO_HOST, 16'h0000);
      // A second stalled seek, cleared by writing a zero into its bit
      go(`FN_SEEK);
      tick(30);
      rd(`ADDR_ERROR_TWO_HOST, 16'h4000);
      wr(`ADDR_ERROR_TWO_HOST, 16'hBFFF);
      rd(`ADDR_ERROR_TWO_HOST, 16'h0000);
      for (int i = 0; i < 6; i++) begin
         volume_valid = i[0];
         medium_online = !i[0];
         go(fns[i]);
         tick();
         if (fns[i] == `FN_DRIVE_CLEAR) ee = 0;
         else if (fns[i] == `FN_SEARCH || fns[i] == `FN_DATA_FIRST) ee = 16'h1000;
         rd(`ADDR_ERROR_TWO_HOST, 16'(ee));
      end
      volume_valid = 1;
      medium_online = 1;
      wr(`ADDR_ERROR_TWO_SYS, 16'hEFFF);
      rd(`ADDR_ERROR_TWO_SYS, 16'h0000);
      for (int i = 0; i < 3; i++) begin
         header_compare_inhibit = (i == 2);
         tick();
         hdr_word = hw[i];
         hdr_valid = 1;
         tick();
         hdr_valid = 0;
         tick();
         ee = (!header_compare_inhibit && hw[i][15:14] != 2'b11) ? 16'h8000 : 0;
         rd(`ADDR_ERROR_TWO_HOST, 16'(ee));
         cmp(16'(header_check_en), 16'(!header_compare_inhibit));
         wr(`ADDR_ERROR_TWO_HOST, 16'h7FFF);
      end
      header_compare_inhibit = 0;
      fault_on = 1;
      for (w = 0; w < 20 && unsafe_flag !== 1'b1; w++) tick();
      if (w == 20) begin
         num_errors++;
         $display("wrong value at %0t: unsafe flag never rose", $time);
      end
      rd(`ADDR_ERROR_TWO_SYS, 16'h0080);
      fault_on = 0;
      tick(10);
      cmp(16'(unsafe_flag), 16'h0000);
      wr(`ADDR_ERROR_TWO_SYS, 16'hFF7F);
      rd(`ADDR_ERROR_TWO_SYS, 16'h0000);
      // Bus initialize in mid-run clears the flags and the target cylinder
      volume_valid = 0;
      go(`FN_SEARCH);
      volume_valid = 1;
      rd(`ADDR_ERROR_TWO_HOST, 16'h1000);
      rst_n = 0;
      tick(2);
      rst_n = 1;
      rd(`ADDR_ERROR_TWO_HOST, 16'h0000);
      rd(`ADDR_TARGET_CYL_SYS, 16'h0000);
      cmp(16'(cylinder_field), 16'h0000);
      close_out();
   end
endmodule
